//--- design/charger_timing.v
// charger tick dividers, safety timers, status leds and static selects
`timescale 1ns/1ps
`default_nettype none
`include "charger_timing_defines.vh"
// Contract
// - divide oscillator into seconds tick, then seconds into minutes tick
// - charging led runs from seconds tick, safety timers from minutes tick
// - each timer starts with its stage and flags expiry after programmed minutes
// - durations in minutes: 8-bit precondition/top-off, 16-bit charging
// - defaults: 30, 300 and 30 minutes until reprogrammed
// - charging led: short pulses, 50:50, or long pulses by stage
// - charging led steady on in maintenance, off with no battery
// - fault led on while battery judged bad
// - counter makes symmetric square wave from seconds tick
// - voltage select active only for the highest regulation setting
// - precondition level output drives open drain only at 40 percent
// - sense scaling on during top-off stage
// - precondition and top-off enables routed to stage-transition logic
// - readback of state, timer counts, pins and settings
// - three control bits disable charger, preconditioning, top-off; reset zero
// - stage signals active high while in that stage
module charger_timing #(
    parameter SEC_DIV = `SEC_DIV_CYCLES,
    parameter MIN_DIV = `MIN_DIV_SECONDS
) (
    input wire clk,
    input wire rst,
    input wire st_precondition,
    input wire st_charging,
    input wire st_topoff,
    input wire st_maintenance,
    input wire st_no_battery,
    input wire st_bad_battery,
    input wire [2:0] asm_state,
    input wire prec_time_we,
    input wire [7:0] prec_time_in,
    input wire chg_time_we,
    input wire [15:0] chg_time_in,
    input wire top_time_we,
    input wire [7:0] top_time_in,
    input wire ctrl_we,
    input wire charger_disable_in,
    input wire precondition_disable_in,
    input wire topoff_disable_in,
    input wire [1:0] vreg_sel,
    input wire [1:0] prec_level_sel,
    input wire [1:0] eoc_sel,
    input wire enable_pin,
    output reg charger_disable_bit,
    output reg precondition_disable_bit,
    output reg topoff_disable_bit,
    output wire prec_timeout,
    output wire chg_timeout,
    output wire top_timeout,
    output reg charge_led_r,
    output reg fault_led_r,
    output reg voltage_select_out,
    output reg precondition_level_out,
    output reg precondition_level_oe,
    output reg sense_scale_out,
    output reg [7:0] prec_count_rd,
    output reg [15:0] chg_count_rd,
    output reg [7:0] top_count_rd,
    output reg [7:0] prec_time_rd,
    output reg [15:0] chg_time_rd,
    output reg [7:0] top_time_rd,
    output reg [2:0] state_rd,
    output reg [5:0] stage_rd,
    output reg [6:0] settings_rd,
    output reg enable_pin_rd
);
    localparam [1:0] VREG_438 = 2'h3;
    localparam [1:0] PREC_40 = 2'h2;
    localparam [1:0] LED_OFF = 2'h0;
    localparam [1:0] LED_SHORT = 2'h1;
    localparam [1:0] LED_HALF = 2'h2;
    localparam [1:0] LED_LONG = 2'h3;

    reg [15:0] sec_cnt_r;
    reg [5:0] min_cnt_r;
    reg sec_tick_r;
    reg min_tick_r;
    reg square_r;
    reg [1:0] phase_r;
    reg [7:0] prec_time_r;
    reg [15:0] chg_time_r;
    reg [7:0] top_time_r;
    reg [2:0] pin_sync_r;
    reg pin_level_r;
    reg [1:0] led_mode;
    reg led_nxt;
    wire [7:0] prec_cnt;
    wire [15:0] chg_cnt;
    wire [7:0] top_cnt;

    // cascaded dividers: oscillator to seconds, seconds to minutes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sec_cnt_r <= 16'h0000;
            min_cnt_r <= 6'h00;
            sec_tick_r <= 1'b0;
            min_tick_r <= 1'b0;
        end else begin
            sec_tick_r <= 1'b0;
            min_tick_r <= 1'b0;
            if (sec_cnt_r == SEC_DIV[15:0] - 16'h0001) begin
                sec_cnt_r <= 16'h0000;
                sec_tick_r <= 1'b1;
                if (min_cnt_r == MIN_DIV[5:0] - 6'h01) begin
                    min_cnt_r <= 6'h00;
                    min_tick_r <= 1'b1;
                end else begin
                    min_cnt_r <= min_cnt_r + 6'h01;
                end
            end else begin
                sec_cnt_r <= sec_cnt_r + 16'h0001;
            end
        end
    end

    // square wave and short/long pulse phase, both on the seconds tick
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            square_r <= 1'b0;
            phase_r <= 2'h0;
        end else if (sec_tick_r) begin
            square_r <= ~square_r;
            phase_r <= phase_r + 2'h1;
        end
    end

    // programmable durations and control bits, powered up at defaults
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prec_time_r <= `PREC_TIME_DEFAULT;
            chg_time_r <= `CHG_TIME_DEFAULT;
            top_time_r <= `TOP_TIME_DEFAULT;
            charger_disable_bit <= 1'b0;
            precondition_disable_bit <= 1'b0;
            topoff_disable_bit <= 1'b0;
        end else begin
            // zero is out of range, so such writes are ignored
            if (prec_time_we && prec_time_in != 8'h00) begin
                prec_time_r <= prec_time_in;
            end
            if (chg_time_we && chg_time_in != 16'h0000) begin
                chg_time_r <= chg_time_in;
            end
            if (top_time_we && top_time_in != 8'h00) begin
                top_time_r <= top_time_in;
            end
            if (ctrl_we) begin
                charger_disable_bit <= charger_disable_in;
                precondition_disable_bit <= precondition_disable_in;
                topoff_disable_bit <= topoff_disable_in;
            end
        end
    end

    stage_timer #(.W(8)) prec_timer (
        .clk(clk),
        .rst(rst),
        .stage_active(st_precondition),
        .minute_tick(min_tick_r),
        .duration(prec_time_r),
        .count_r(prec_cnt),
        .expired_r(prec_timeout)
    );
    stage_timer #(.W(16)) chg_timer (
        .clk(clk),
        .rst(rst),
        .stage_active(st_charging),
        .minute_tick(min_tick_r),
        .duration(chg_time_r),
        .count_r(chg_cnt),
        .expired_r(chg_timeout)
    );
    stage_timer #(.W(8)) top_timer (
        .clk(clk),
        .rst(rst),
        .stage_active(st_topoff),
        .minute_tick(min_tick_r),
        .duration(top_time_r),
        .count_r(top_cnt),
        .expired_r(top_timeout)
    );

    // three-stage input synchroniser for the enable pin
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_sync_r <= 3'h7;
            pin_level_r <= 1'b1;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], enable_pin};
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                pin_level_r <= pin_sync_r[2];
            end
        end
    end

    // led pattern select; short = one second on in four
    always @* begin
        led_mode = LED_OFF;
        if (st_precondition) begin
            led_mode = LED_SHORT;
        end else if (st_charging) begin
            led_mode = LED_HALF;
        end else if (st_topoff) begin
            led_mode = LED_LONG;
        end
        case (led_mode)
            LED_SHORT: led_nxt = (phase_r == 2'h0);
            LED_HALF: led_nxt = square_r;
            LED_LONG: led_nxt = (phase_r != 2'h0);
            default: led_nxt = st_maintenance && !st_no_battery;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            charge_led_r <= 1'b0;
            fault_led_r <= 1'b0;
            voltage_select_out <= 1'b0;
            precondition_level_out <= 1'b0;
            precondition_level_oe <= 1'b0;
            sense_scale_out <= 1'b0;
            prec_count_rd <= 8'h00;
            chg_count_rd <= 16'h0000;
            top_count_rd <= 8'h00;
            prec_time_rd <= `PREC_TIME_DEFAULT;
            chg_time_rd <= `CHG_TIME_DEFAULT;
            top_time_rd <= `TOP_TIME_DEFAULT;
            state_rd <= 3'h0;
            stage_rd <= 6'h00;
            settings_rd <= 7'h00;
            enable_pin_rd <= 1'b1;
        end else begin
            charge_led_r <= led_nxt;
            fault_led_r <= st_bad_battery;
            voltage_select_out <= (vreg_sel == VREG_438);
            // open drain: pulls low only, released otherwise
            precondition_level_out <= 1'b0;
            precondition_level_oe <= (prec_level_sel == PREC_40);
            sense_scale_out <= st_topoff;
            prec_count_rd <= prec_cnt;
            chg_count_rd <= chg_cnt;
            top_count_rd <= top_cnt;
            prec_time_rd <= prec_time_r;
            chg_time_rd <= chg_time_r;
            top_time_rd <= top_time_r;
            state_rd <= asm_state;
            stage_rd <= {st_bad_battery, st_no_battery, st_maintenance,
                st_topoff, st_charging, st_precondition};
            settings_rd <= {eoc_sel, prec_level_sel, vreg_sel, sense_scale_out};
            enable_pin_rd <= pin_level_r;
        end
    end
endmodule
`default_nettype wire

//--- design/stage_timer.v
// one safety timer counting minutes while its stage is active
`timescale 1ns/1ps
`default_nettype none
module stage_timer #(
    parameter W = 8
) (
    input wire clk,
    input wire rst,
    input wire stage_active,
    input wire minute_tick,
    input wire [W-1:0] duration,
    output reg [W-1:0] count_r,
    output reg expired_r
);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= {W{1'b0}};
            expired_r <= 1'b0;
        end else if (!stage_active) begin
            count_r <= {W{1'b0}};
            expired_r <= 1'b0;
        end else if (minute_tick && !expired_r) begin
            // a duration of zero is outside range; treated as one minute
            if (count_r + {{(W-1){1'b0}}, 1'b1} >= duration) begin
                expired_r <= 1'b1;
            end
            count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

//--- include/charger_timing_defines.vh
// constants for the charger timing and indication block
`ifndef CHARGER_TIMING_DEFINES_VH
`define CHARGER_TIMING_DEFINES_VH

`define OSC_FREQ_HZ 25000
`define SEC_DIV_CYCLES 25000
`define MIN_DIV_SECONDS 60
`define PREC_TIME_DEFAULT 8'h1E
`define CHG_TIME_DEFAULT 16'h012C
`define TOP_TIME_DEFAULT 8'h1E
`define SQUARE_HALF_SECONDS 1

`endif

//--- test/charge_sm_model.sv
// charge state machine stand-in driving one-hot stage levels
`timescale 1ns/1ps
`default_nettype none
module charge_sm_model (
    input wire logic clk,
    input wire logic [2:0] mode,
    output logic [5:0] stage,
    output logic [2:0] state
);
    logic [2:0] mode_q = 3'h0;
    initial begin
        stage = 6'h00;
        state = 3'h0;
    end
    // mode taken on the rising edge, shown on the falling one:
    // the bench also writes mode on the falling edge, so no race
    always @(posedge clk) begin
        mode_q <= mode;
    end
    always @(negedge clk) begin
        state <= mode_q;
        stage <= (mode_q == 3'h0) ? 6'h00 : 6'h01 << (mode_q - 3'h1);
    end
endmodule
`default_nettype wire

//--- test/charger_timing_monitor.sv
// assertion checker for the charger timing block
`timescale 1ns/1ps
`default_nettype none
module charger_timing_monitor #(
    parameter SEC_DIV = 4,
    parameter MIN_DIV = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] vreg_sel,
    input wire logic [1:0] prec_level_sel,
    input wire logic st_precondition,
    input wire logic st_charging,
    input wire logic st_topoff,
    input wire logic st_bad_battery,
    input wire logic ctrl_we,
    input wire logic charger_disable_in,
    input wire logic charger_disable_bit,
    input wire logic prec_timeout,
    input wire logic chg_timeout,
    input wire logic top_timeout,
    input wire logic fault_led_r,
    input wire logic voltage_select_out,
    input wire logic precondition_level_out,
    input wire logic precondition_level_oe,
    input wire logic sense_scale_out
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_VSEL: assert property (!$past(rst) |-> voltage_select_out == ($past(vreg_sel) == 2'h3))
        else $error("voltage select mismatch");
    AST_PREC_OE: assert property (!$past(rst) |-> precondition_level_oe == ($past(prec_level_sel) == 2'h2))
        else $error("precondition oe mismatch");
    AST_OD_LOW: assert property (!precondition_level_out)
        else $error("open drain level driven high");
    AST_SCALE: assert property (!$past(rst) |-> sense_scale_out == $past(st_topoff))
        else $error("sense scale does not follow top-off");
    AST_FAULT: assert property (!$past(rst) |-> fault_led_r == $past(st_bad_battery))
        else $error("fault led mismatch");
    AST_PREC_CLR: assert property (!st_precondition |=> !prec_timeout)
        else $error("precondition flag kept");
    AST_CHG_CLR: assert property ($fell(st_charging) |=> !chg_timeout [*2])
        else $error("charging flag kept");
    AST_TOP_SRC: assert property (top_timeout |-> $past(st_topoff))
        else $error("top-off flag without stage");
    AST_CTRL: assert property (ctrl_we |=> charger_disable_bit == $past(charger_disable_in))
        else $error("disable bit not written");
    cover property ($rose(prec_timeout));
    cover property ($rose(chg_timeout));
    cover property ($rose(top_timeout));
endmodule
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the charger timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b1;
    logic rst = 1'b1;
    logic [2:0] mode = 3'h0;
    logic pwe = 1'b0, cwe = 1'b0, twe = 1'b0, kwe = 1'b0, en = 1'b1;
    logic [7:0] pin = 8'h00, tin = 8'h00;
    logic [15:0] cin = 16'h0000;
    logic [2:0] kin = 3'h0;
    logic [1:0] vs = 2'h0, ps = 2'h0, es = 2'h0;
    wire logic [5:0] stage;
    wire logic [2:0] state, dis, tmo, strd;
    wire logic led, flt, vsel, oe, scl, enrd;
    wire logic [7:0] pcnt, tcnt, ptim, ttim;
    wire logic [15:0] ccnt, ctim;
    wire logic [6:0] set;
    wire logic [5:0] srd;
    int n_mismatch = 0;
    int cmp_count = 0;
    int i, k;
    int on_cnt[7] = '{0, 8, 16, 24, 32, 0, 0};
    always #20 clk = ~clk;
    charge_sm_model sm_u (.clk(clk), .mode(mode), .stage(stage), .state(state));
    charger_timing #(.SEC_DIV(4), .MIN_DIV(3)) dut_u (
        .clk(clk), .rst(rst), .st_precondition(stage[0]), .st_charging(stage[1]),
        .st_topoff(stage[2]), .st_maintenance(stage[3]), .st_no_battery(stage[4]),
        .st_bad_battery(stage[5]), .asm_state(state), .prec_time_we(pwe),
        .prec_time_in(pin), .chg_time_we(cwe), .chg_time_in(cin), .top_time_we(twe),
        .top_time_in(tin), .ctrl_we(kwe), .charger_disable_in(kin[0]),
        .precondition_disable_in(kin[1]), .topoff_disable_in(kin[2]), .vreg_sel(vs),
        .prec_level_sel(ps), .eoc_sel(es), .enable_pin(en), .charger_disable_bit(dis[0]),
        .precondition_disable_bit(dis[1]), .topoff_disable_bit(dis[2]),
        .prec_timeout(tmo[0]), .chg_timeout(tmo[1]), .top_timeout(tmo[2]),
        .charge_led_r(led), .fault_led_r(flt), .voltage_select_out(vsel),
        .precondition_level_out(), .precondition_level_oe(oe), .sense_scale_out(scl),
        .prec_count_rd(pcnt), .chg_count_rd(ccnt), .top_count_rd(tcnt),
        .prec_time_rd(ptim), .chg_time_rd(ctim), .top_time_rd(ttim), .state_rd(strd),
        .stage_rd(srd), .settings_rd(set), .enable_pin_rd(enrd)
    );
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one-cycle write strobe; data fields shared, only the strobe selects
    task automatic wr(input int which, input logic [15:0] v);
        pin = v[7:0];
        cin = v;
        tin = v[7:0];
        kin = v[2:0];
        {kwe, twe, cwe, pwe} = 4'h1 << which;
        cyc(1);
        {kwe, twe, cwe, pwe} = 4'h0;
        cyc(3);
    endtask
    function automatic logic [15:0] cnt_of(input int t);
        return t == 1 ? ccnt : (t == 0 ? {8'h00, pcnt} : {8'h00, tcnt});
    endfunction
    // one minute is 12 clock cycles with the shortened dividers
    task automatic t_timer(input logic [2:0] m, input int d, input int t);
        int n;
        n = 0;
        mode = m;
        while (tmo[t] !== 1'b1 && n < d * 12 + 8) begin
            cyc(1);
            n++;
        end
        check("expiry in time", n < d * 12 + 8, 1'b1);
        if (n >= d * 12 + 8) begin
            finish_test();
        end
        check("expiry not early", n > (d - 1) * 12, 1'b1);
        cyc(3);
        check("count at expiry", cnt_of(t), d[15:0]);
        mode = 3'h0;
        cyc(4);
        check("flag cleared", tmo[t], 1'b0);
        check("count cleared", cnt_of(t), 16'h0000);
    endtask
    task automatic t_led;
        for (i = 1; i < 7; i++) begin
            mode = i[2:0];
            cyc(4);
            k = 0;
            repeat (32) begin
                cyc(1);
                k += (led === 1'b1);
            end
            check("led on cycles", k, on_cnt[i]);
            check("fault led", flt, i == 6);
            check("sense scale", scl, i == 3);
            check("state readback", strd, i);
            check("stage readback", srd, 16'h0001 << (i - 1));
        end
        mode = 3'h0;
    endtask
    task automatic t_static;
        for (i = 0; i < 4; i++) begin
            vs = i[1:0];
            ps = i[1:0];
            es = i[1:0];
            en = i[0];
            cyc(5);
            check("voltage select", vsel, i == 3);
            check("precondition oe", oe, i == 2);
            check("eoc readback", set[6:5], i);
            check("settings readback", set, {i[1:0], i[1:0], i[1:0], 1'b0});
            check("enable pin readback", enrd, i[0]);
        end
    endtask
    task automatic t_ctrl;
        for (i = 0; i < 4; i++) begin
            wr(3, 16'h0001 << i);
            check("disable bits", dis, (16'h0001 << i) & 16'h0007);
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        cyc(1);
        rst = 1'b0;
        cyc(3);
        check("precondition default", ptim, 8'h1E);
        check("charging default", ctim, 16'h012C);
        check("top-off default", ttim, 8'h1E);
        check("disable bits reset", dis, 3'h0);
        t_static();
        t_ctrl();
        t_led();
        wr(0, 16'h0002);
        wr(0, 16'h0000);
        check("zero write ignored", ptim, 8'h02);
        t_timer(3'h1, 2, 0);
        wr(1, 16'h0102);
        t_timer(3'h2, 258, 1);
        wr(2, 16'h0000);
        check("top-off default kept", ttim, 8'h1E);
        t_timer(3'h3, 30, 2);
        finish_test();
    end
endmodule
bind charger_timing charger_timing_monitor #(.SEC_DIV(SEC_DIV), .MIN_DIV(MIN_DIV)) mon_u (
    .clk(clk), .rst(rst), .vreg_sel(vreg_sel), .prec_level_sel(prec_level_sel),
    .st_precondition(st_precondition), .st_charging(st_charging), .st_topoff(st_topoff),
    .st_bad_battery(st_bad_battery), .ctrl_we(ctrl_we),
    .charger_disable_in(charger_disable_in), .charger_disable_bit(charger_disable_bit),
    .prec_timeout(prec_timeout), .chg_timeout(chg_timeout), .top_timeout(top_timeout),
    .fault_led_r(fault_led_r), .voltage_select_out(voltage_select_out),
    .precondition_level_out(precondition_level_out),
    .precondition_level_oe(precondition_level_oe), .sense_scale_out(sense_scale_out)
);
`default_nettype wire
